// File: tb/keypad_model.sv
// Operator side of the front panel: issues key presses.
// Assumes keys are sampled on the rising edge of clk_sys.
`timescale 1ns/1ps
module keypad_model (
	// Clock
	input  wire logic clk_sys,
	// Keys
	output logic      key_mode,
	output logic      key_arrow,
	output logic      key_inc,
	output logic      value_down_key
);

	////////////////////////////////////////////////////////////////////////////
	// All keys released until the bench asks for a press
	initial begin
		{key_mode, key_arrow, key_inc, value_down_key} = 4'h0;
	end

	// One-cycle press then a gap; the display register lags the store read by a cycle
	// k: 0 mode, 1 arrow, 2 inc, 3 down; n presses in a row
	task automatic press(input int k, input int n);
		repeat (n) begin
			@(negedge clk_sys);
			{key_mode, key_arrow, key_inc, value_down_key} = 4'(4'h8 >> k);
			@(negedge clk_sys);
			{key_mode, key_arrow, key_inc, value_down_key} = 4'h0;
			repeat (3) @(negedge clk_sys);
		end
	endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench of the limit switch programming controller.
// Assumes shortened display and idle counts; keys come from the keypad model.
`timescale 1ns/1ps
module tb_top
	import pls_pkg::*;
;
	localparam int SHOW = 20;
	localparam int TMO  = 50;

	typedef struct {
		logic [8:0] ang;
		logic [8:0] pos;
	} row_s;

	logic       clk_sys, rst_n, clk_en, factory_clear, prog_enable;
	logic [8:0] resolver_angle;
	logic       key_mode, key_arrow, key_inc, value_down_key;
	logic [3:0] disp_left_chan;
	logic       disp_left_blank, led_position, led_tach, led_offset;
	sym_e       disp_right_sym;
	logic [8:0] disp_right_val, position_out;
	logic       turn_on_angle_indicator, turn_off_angle_indicator, dp_left_blink, dp_right_blink;
	logic [7:0] chan_out;
	int         fail_count, checked, cycles;
	// Offset is 359 while these rows run
	row_s       rows [4] = '{'{9'h000, 9'h167}, '{9'h001, 9'h000}, '{9'h0C8, 9'h0C7}, '{9'h167, 9'h166}};

	////////////////////////////////////////////////////////////////////////////
	keypad_model KP (.clk_sys(clk_sys), .key_mode(key_mode), .key_arrow(key_arrow),
		.key_inc(key_inc), .value_down_key(value_down_key));

	limit_switch_programming_fsm #(.SHOW_CYCLES(32'd20), .TIMEOUT_CYCLES(32'd50)) DUT (
		.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .factory_clear(factory_clear),
		.resolver_angle(resolver_angle), .prog_enable(prog_enable), .key_mode(key_mode),
		.key_arrow(key_arrow), .key_inc(key_inc), .value_down_key(value_down_key),
		.disp_left_chan(disp_left_chan), .disp_left_blank(disp_left_blank),
		.disp_right_sym(disp_right_sym), .disp_right_val(disp_right_val),
		.led_position(led_position), .led_tach(led_tach), .led_offset(led_offset),
		.turn_on_angle_indicator(turn_on_angle_indicator),
		.turn_off_angle_indicator(turn_off_angle_indicator), .dp_left_blink(dp_left_blink),
		.dp_right_blink(dp_right_blink), .position_out(position_out), .chan_out(chan_out));

	////////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare tasks, one per kind of result
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %0b seen %0b", nm, e, g);
		end
	endtask

	task automatic chk9(input string nm, input logic [8:0] e, input logic [8:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk_sym(input sym_e e);
		checked++;
		if (disp_right_sym !== e) begin
			fail_count++;
			$display("ERROR right_symbol expected %0h seen %0h", e, disp_right_sym);
		end
	endtask

	// Channel outputs are scanned, so allow the scan to come round
	task automatic set_ang(input logic [8:0] a);
		resolver_angle = a;
		repeat (12) @(negedge clk_sys);
	endtask

	task automatic stop_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; all inputs change on the falling edge
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		// Store and offset ignore reset, so empty them while reset is held
		factory_clear = 1'b1;
		prog_enable = 1'b1;
		resolver_angle = 9'h064;
		repeat (8) @(negedge clk_sys);
		factory_clear = 1'b0;
		chk9("chan_in_reset", 9'h001, {5'h00, disp_left_chan});
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk1("led_position", 1'b1, led_position);
		KP.press(0, 1);
		chk1("led_tach", 1'b1, led_tach);
		KP.press(0, 1);
		chk1("led_offset", 1'b1, led_offset);
		chk9("offset_shown", 9'h000, disp_right_val);
		repeat (SHOW + 5) @(negedge clk_sys);
		chk9("position_shown", 9'h064, disp_right_val);
		// Offset 0 down to 359, then the position table
		KP.press(3, 1);
		foreach (rows[i]) begin
			resolver_angle = rows[i].ang;
			repeat (3) @(negedge clk_sys);
			chk9("position", rows[i].pos, position_out);
		end
		// Change attempt with programming disabled
		prog_enable = 1'b0;
		KP.press(2, 1);
		chk1("refused_to_position", 1'b1, led_position);
		chk9("offset_kept", 9'h166, position_out);
		prog_enable = 1'b1;
		KP.press(0, 2);
		KP.press(2, 2);
		chk9("offset_up_wrap", 9'h000, position_out);
		// Channel mode, channel selection saturates
		KP.press(0, 1);
		chk1("leds_off", 1'b0, led_position | led_tach | led_offset | turn_on_angle_indicator);
		chk1("left_dot", 1'b1, dp_left_blink);
		chk1("left_shown", 1'b0, disp_left_blank);
		chk_sym(SYM_NULL);
		KP.press(3, 1);
		chk9("chan_low", 9'h001, {5'h00, disp_left_chan});
		for (int i = 2; i <= 9; i++) begin
			KP.press(2, 1);
			chk9("chan_sel", 9'((i > 8) ? 8 : i), {5'h00, disp_left_chan});
		end
		chk9("offset_untouched", 9'h000, position_out);
		// New pair 5..10 on channel 8
		KP.press(1, 1);
		chk1("on_led", 1'b1, turn_on_angle_indicator);
		chk1("left_dot_off", 1'b0, dp_left_blink);
		chk1("right_dot", 1'b1, dp_right_blink);
		chk9("null_to_zero", 9'h000, disp_right_val);
		KP.press(2, 5);
		KP.press(1, 1);
		chk1("off_led", 1'b1, turn_off_angle_indicator);
		chk1("on_led_out", 1'b0, turn_on_angle_indicator);
		chk9("off_from_on", 9'h005, disp_right_val);
		KP.press(2, 5);
		KP.press(1, 1);
		chk9("chan_on_value", 9'h005, disp_right_val);
		set_ang(9'h006);
		chk1("out_inside", 1'b1, chan_out[7]);
		set_ang(9'h009);
		chk1("out_at_off", 1'b0, chan_out[7]);
		set_ang(9'h003);
		chk1("out_below", 1'b0, chan_out[7]);
		// Existing pair, then raise on to off to delete it
		KP.press(1, 1);
		chk1("on_led_pair", 1'b1, turn_on_angle_indicator);
		chk1("left_dot_pair", 1'b1, dp_left_blink);
		chk9("on_pair_value", 9'h005, disp_right_val);
		KP.press(2, 5);
		KP.press(0, 4);
		chk_sym(SYM_NULL);
		// Pair 3..6, then lower off to on to delete it
		KP.press(1, 1);
		KP.press(2, 3);
		KP.press(1, 1);
		KP.press(2, 3);
		KP.press(1, 3);
		chk9("off_recalled", 9'h006, disp_right_val);
		KP.press(3, 3);
		KP.press(0, 4);
		chk_sym(SYM_NULL);
		// Untouched null pair exits fully on
		KP.press(1, 3);
		chk_sym(SYM_ALL);
		set_ang(9'h100);
		chk1("out_all", 1'b1, chan_out[7]);
		KP.press(1, 1);
		chk_sym(SYM_VALUE);
		chk9("all_to_zero", 9'h000, disp_right_val);
		KP.press(2, 2);
		KP.press(1, 1);
		chk9("all_off_tracks", 9'h002, disp_right_val);
		KP.press(1, 1);
		chk_sym(SYM_ALL);
		// Idle time-out from channel mode
		repeat (TMO + 10) @(negedge clk_sys);
		chk1("timeout", 1'b1, led_position);
		// Reset mid-run keeps the store, channel back to 1
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		@(negedge clk_sys);
		KP.press(0, 3);
		chk9("chan_after_reset", 9'h001, {5'h00, disp_left_chan});
		// A key while the enable is low must be lost
		clk_en = 1'b0;
		KP.press(2, 1);
		clk_en = 1'b1;
		@(negedge clk_sys);
		chk9("chan_frozen", 9'h001, {5'h00, disp_left_chan});
		KP.press(2, 7);
		chk_sym(SYM_ALL);
		// Setpoint wraps below zero
		KP.press(1, 1);
		KP.press(3, 1);
		chk9("setpoint_wrap", 9'h167, disp_right_val);
		stop_test();
	end
endmodule

// File: verilog/limit_switch_programming_fsm.sv
// Front panel programming controller of an eight channel limit switch.
// Assumes keys are one-cycle press pulses synchronous to clk_sys.
// Operation
// RULE_01 - Offset mode shows offset 2.5 s first
// RULE_02 - Position equals resolver angle plus offset
// RULE_03 - Enabled keys adjust offset within 0..359
// RULE_04 - Corrected position above 359 wraps to 0
// RULE_05 - Corrected position below 0 wraps to 359
// RULE_06 - Channel mode shows channel, on value, left dot
// RULE_07 - Channel keys change channel only, 1..8
// RULE_08 - Empty channel shows null; factory state empty
// RULE_09 - Arrow enters on mode; null becomes 0
// RULE_10 - Existing pair: display unchanged except on LED
// RULE_11 - Off value tracks on value from null
// RULE_12 - Arrow enters off mode, shows existing off
// RULE_13 - Off value from null starts at on
// RULE_14 - On raised to off or above deletes pair
// RULE_15 - Off lowered to on or below deletes
// RULE_16 - Off at or below on exits fully on
// RULE_17 - Fully on channel shows 0 in on mode
// RULE_18 - Fully on reprograms like an empty channel
// RULE_19 - Disabled change attempt returns to position mode
// RULE_20 - One idle minute returns to position mode
// RULE_21 - Mode key cycles position, tach, offset, channel
// RULE_22 - Values persist; channel resets to 1
// RULE_23 - Output active from on to off setpoint
// RULE_24 - Setpoints wrap within 0..359
`timescale 1ns/1ps
module limit_switch_programming_fsm
	import pls_pkg::*;
#(
	parameter logic [31:0] SHOW_CYCLES    = 32'(OFFSET_SHOW_CYC),
	parameter logic [31:0] TIMEOUT_CYCLES = 32'(IDLE_TIMEOUT_CYC)
)(
	// Clock, reset, enable
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       factory_clear,
	// Position source and enable strap
	input  wire logic [8:0] resolver_angle,
	input  wire logic       prog_enable,
	// Keys
	input  wire logic       key_mode,
	input  wire logic       key_arrow,
	input  wire logic       key_inc,
	input  wire logic       value_down_key,
	// Display
	output logic [3:0]      disp_left_chan,
	output logic            disp_left_blank,
	output sym_e            disp_right_sym,
	output logic [8:0]      disp_right_val,
	output logic            led_position,
	output logic            led_tach,
	output logic            led_offset,
	output logic            turn_on_angle_indicator,
	output logic            turn_off_angle_indicator,
	output logic            dp_left_blink,
	output logic            dp_right_blink,
	// Results
	output logic [8:0]      position_out,
	output logic [7:0]      chan_out
);

	sp_mem_if mif ();

	mode_e       mode_r, mode_nxt;
	logic [8:0]  offset_r, offset_nxt;
	logic [3:0]  sel_chan_r, sel_chan_nxt;
	logic        track_r, track_nxt;
	logic [31:0] show_cnt_r, idle_cnt_r;
	logic [2:0]  scan_addr_r, scan_idx_r;
	logic        we_nxt;
	sp_entry_s   wdata_nxt;

	////////////////////////////////////////////////////////////////////////
	// Angle arithmetic
	function automatic logic [8:0] ang_inc(input logic [8:0] a);
		return (a == ANGLE_MAX) ? ANGLE_ZERO : 9'(a + 9'h001);
	endfunction

	function automatic logic [8:0] ang_dec(input logic [8:0] a);
		return (a == ANGLE_ZERO) ? ANGLE_MAX : 9'(a - 9'h001);
	endfunction

	// Corrected position, folded into one turn
	wire logic [9:0] pos_sum  = {1'b0, resolver_angle} + {1'b0, offset_r};
	wire logic [8:0] corr_pos = (pos_sum >= ANGLE_SPAN) ? 9'(pos_sum - ANGLE_SPAN) : pos_sum[8:0]; // RULE_02

	// Key and mode decode
	wire logic      any_key   = key_mode | key_arrow | key_inc | value_down_key;
	wire logic      step_key  = key_inc | value_down_key;
	wire logic      prog_mode = (mode_r == M_OFFS) || (mode_r == M_CHAN) || (mode_r == M_ONSP) || (mode_r == M_OFFSP);
	wire logic      time_up   = prog_mode && (idle_cnt_r == TIMEOUT_CYCLES - 32'h1);
	wire sp_entry_s cur       = mif.rdata;
	wire logic [8:0] on_step  = key_inc ? ang_inc(cur.on_ang) : ang_dec(cur.on_ang);   // RULE_24
	wire logic [8:0] off_step = key_inc ? ang_inc(cur.off_ang) : ang_dec(cur.off_ang); // RULE_24

	////////////////////////////////////////////////////////////////////////
	// Mode sequencing and setpoint edits
	always_comb begin
		mode_nxt     = mode_r;
		offset_nxt   = offset_r;
		sel_chan_nxt = sel_chan_r;
		track_nxt    = track_r;
		we_nxt       = 1'b0;
		wdata_nxt    = cur;
		if (key_mode) begin
			track_nxt = 1'b0;
			unique case (mode_r)
				M_POS:   mode_nxt = M_TACH; // RULE_21
				M_TACH:  mode_nxt = M_OFFS;
				M_OFFS:  mode_nxt = M_CHAN;
				default: mode_nxt = M_POS;
			endcase
		end else if (time_up) begin
			mode_nxt  = M_POS; // RULE_20
			track_nxt = 1'b0;
		end else begin
			unique case (mode_r)
				M_POS, M_TACH: begin
				end
				M_OFFS: begin
					if (step_key && !prog_enable) begin
						mode_nxt = M_POS; // RULE_19
					end else if (step_key) begin
						offset_nxt = key_inc ? ang_inc(offset_r) : ang_dec(offset_r); // RULE_03 RULE_04 RULE_05
					end
				end
				M_CHAN: begin
					if (key_arrow && !prog_enable) begin
						mode_nxt = M_POS; // RULE_19
					end else if (key_arrow) begin
						mode_nxt = M_ONSP; // RULE_09
						if (cur.st != SP_PAIR) begin
							we_nxt    = 1'b1; // RULE_09 RULE_17 RULE_18
							wdata_nxt = '{st: SP_PAIR, on_ang: ANGLE_ZERO, off_ang: ANGLE_ZERO};
							track_nxt = 1'b1;
						end
					end else if (key_inc) begin
						sel_chan_nxt = (sel_chan_r == CHAN_MAX) ? CHAN_MAX : 4'(sel_chan_r + 4'h1); // RULE_07
					end else if (value_down_key) begin
						sel_chan_nxt = (sel_chan_r == CHAN_MIN) ? CHAN_MIN : 4'(sel_chan_r - 4'h1); // RULE_07
					end
				end
				M_ONSP: begin
					if ((key_arrow || step_key) && !prog_enable) begin
						mode_nxt  = M_POS; // RULE_19
						track_nxt = 1'b0;
					end else if (key_arrow) begin
						mode_nxt  = M_OFFSP; // RULE_12 RULE_13
						track_nxt = 1'b0;
					end else if (step_key && cur.st == SP_PAIR) begin
						we_nxt           = 1'b1;
						wdata_nxt.on_ang = on_step;
						if (track_r) begin
							wdata_nxt.off_ang = on_step; // RULE_11
						end else if (key_inc && on_step >= cur.off_ang) begin
							wdata_nxt = ENTRY_EMPTY; // RULE_14
						end
					end
				end
				M_OFFSP: begin
					if ((key_arrow || step_key) && !prog_enable) begin
						mode_nxt = M_POS; // RULE_19
					end else if (key_arrow) begin
						mode_nxt = M_CHAN;
						if (cur.st == SP_PAIR && cur.off_ang <= cur.on_ang) begin
							we_nxt       = 1'b1; // RULE_16
							wdata_nxt.st = SP_ALL;
						end
					end else if (step_key && cur.st == SP_PAIR) begin
						we_nxt            = 1'b1;
						wdata_nxt.off_ang = off_step;
						if (value_down_key && off_step <= cur.on_ang) begin
							wdata_nxt = ENTRY_EMPTY; // RULE_15
						end
					end
				end
				default: mode_nxt = M_POS;
			endcase
		end
	end

	// Store connections; edit port follows the selected channel
	assign mif.we        = we_nxt && clk_en;
	assign mif.waddr     = 3'(sel_chan_r - CHAN_MIN);
	assign mif.wdata     = wdata_nxt;
	assign mif.raddr     = 3'(sel_chan_nxt - CHAN_MIN);
	assign mif.scan_addr = scan_addr_r;

	setpoint_mem u_mem (
		.clk_sys       (clk_sys),
		.clk_en        (clk_en),
		.factory_clear (factory_clear),
		.port          (mif)
	);

	////////////////////////////////////////////////////////////////////////
	// Control state; channel number is volatile, offset is not
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_r     <= M_POS;
			sel_chan_r <= CHAN_MIN; // RULE_22
			track_r    <= 1'b0;
		end else if (clk_en) begin
			mode_r     <= mode_nxt;
			sel_chan_r <= sel_chan_nxt;
			track_r    <= track_nxt;
		end
	end

	// Offset lives in nonvolatile storage, cleared only at the factory
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			offset_r <= factory_clear ? ANGLE_ZERO : offset_nxt;
		end
	end

	// Offset display hold and keyboard idle timers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			show_cnt_r <= 32'h0;
			idle_cnt_r <= 32'h0;
		end else if (clk_en) begin
			if (mode_nxt == M_OFFS && mode_r != M_OFFS) begin
				show_cnt_r <= SHOW_CYCLES; // RULE_01
			end else if (show_cnt_r != 32'h0) begin
				show_cnt_r <= show_cnt_r - 32'h1;
			end
			idle_cnt_r <= (any_key || !prog_mode || time_up) ? 32'h0 : idle_cnt_r + 32'h1; // RULE_20
		end
	end

	// Scan walks the store so every channel output is refreshed every eight cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scan_addr_r <= 3'h0;
			scan_idx_r  <= 3'h0;
		end else if (clk_en) begin
			scan_addr_r <= 3'(scan_addr_r + 3'h1);
			scan_idx_r  <= scan_addr_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel outputs; a window with on above off spans the zero crossing
	wire sp_entry_s sc      = mif.scan_data;
	wire logic      in_fwd  = (position_out >= sc.on_ang) && (position_out < sc.off_ang);
	wire logic      in_wrap = (position_out >= sc.on_ang) || (position_out < sc.off_ang);
	wire logic      in_win  = (sc.on_ang <= sc.off_ang) ? in_fwd : in_wrap;
	wire logic      sc_act  = (sc.st == SP_ALL) || (sc.st == SP_PAIR && in_win); // RULE_23

	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_out
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				chan_out[g] <= 1'b0;
			end else if (clk_en && scan_idx_r == 3'(g)) begin
				chan_out[g] <= sc_act; // RULE_23
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Display decode
	wire logic chan_view = (mode_r == M_CHAN) || (mode_r == M_ONSP) || (mode_r == M_OFFSP);
	wire logic show_off  = (mode_r == M_OFFS) && (show_cnt_r != 32'h0);
	wire sym_e ent_sym   = (cur.st == SP_NULL) ? SYM_NULL : (cur.st == SP_ALL) ? SYM_ALL : SYM_VALUE; // RULE_08
	wire sym_e r_sym     = (mode_r == M_TACH) ? SYM_BLANK :
	                       (mode_r == M_CHAN) ? ent_sym :
	                       (chan_view && cur.st == SP_NULL) ? SYM_NULL : SYM_VALUE;
	wire logic [8:0] r_val = show_off ? offset_r :                 // RULE_01
	                         (mode_r == M_OFFSP) ? cur.off_ang :   // RULE_12
	                         chan_view ? cur.on_ang : corr_pos;    // RULE_06 RULE_10
	wire logic l_dot = (mode_r == M_CHAN) || (mode_r == M_ONSP && !track_r); // RULE_06 RULE_10
	wire logic r_dot = (mode_r == M_ONSP && track_r) || (mode_r == M_OFFSP);  // RULE_09 RULE_12

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			disp_left_chan           <= CHAN_MIN;
			disp_left_blank          <= 1'b1;
			disp_right_sym           <= SYM_BLANK;
			disp_right_val           <= ANGLE_ZERO;
			led_position             <= 1'b0;
			led_tach                 <= 1'b0;
			led_offset               <= 1'b0;
			turn_on_angle_indicator  <= 1'b0;
			turn_off_angle_indicator <= 1'b0;
			dp_left_blink            <= 1'b0;
			dp_right_blink           <= 1'b0;
			position_out             <= ANGLE_ZERO;
		end else if (clk_en) begin
			disp_left_chan           <= sel_chan_r;
			disp_left_blank          <= !chan_view;
			disp_right_sym           <= r_sym;
			disp_right_val           <= r_val;
			led_position             <= (mode_r == M_POS);
			led_tach                 <= (mode_r == M_TACH);
			led_offset               <= (mode_r == M_OFFS);
			turn_on_angle_indicator  <= (mode_r == M_ONSP);  // RULE_09
			turn_off_angle_indicator <= (mode_r == M_OFFSP); // RULE_12
			dp_left_blink            <= l_dot;
			dp_right_blink           <= r_dot;
			position_out             <= corr_pos;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_chan_arrow;
		clk_en && mode_r == M_CHAN && key_arrow && !key_mode && prog_enable && !time_up;
	endsequence
	sequence s_on_view;
		clk_en ##1 turn_on_angle_indicator && !turn_off_angle_indicator;
	endsequence

	property p_offset_show;
		clk_en && show_off |=> disp_right_val == $past(offset_r);
	endproperty
	a_offset_show: assert property (p_offset_show) else $error("offset not shown while held"); // RULE_01

	property p_corr_pos;
		clk_en |=> position_out == 9'((10'($past(resolver_angle)) + 10'($past(offset_r))) % ANGLE_SPAN);
	endproperty
	a_corr_pos: assert property (p_corr_pos) else $error("corrected position wrong"); // RULE_02

	property p_offset_wrap;
		clk_en && mode_r == M_OFFS && key_inc && !key_mode && prog_enable && !time_up && offset_r == ANGLE_MAX
			|=> offset_r == ANGLE_ZERO;
	endproperty
	a_offset_wrap: assert property (p_offset_wrap) else $error("offset did not wrap to zero"); // RULE_04

	property p_chan_range;
		sel_chan_r >= CHAN_MIN && sel_chan_r <= CHAN_MAX;
	endproperty
	a_chan_range: assert property (p_chan_range) else $error("channel out of range"); // RULE_07

	property p_on_entry;
		s_chan_arrow |=> mode_r == M_ONSP ##0 s_on_view;
	endproperty
	a_on_entry: assert property (p_on_entry) else $error("on mode entry wrong"); // RULE_09

	property p_off_entry;
		clk_en && mode_r == M_ONSP && key_arrow && !key_mode && prog_enable && !time_up
			|=> mode_r == M_OFFSP ##0 clk_en ##1 turn_off_angle_indicator && dp_right_blink;
	endproperty
	a_off_entry: assert property (p_off_entry) else $error("off mode entry wrong"); // RULE_12

	property p_locked;
		clk_en && mode_r == M_OFFS && step_key && !key_mode && !prog_enable && !time_up
			|=> mode_r == M_POS && $stable(offset_r);
	endproperty
	a_locked: assert property (p_locked) else $error("locked change not refused"); // RULE_19

	property p_timeout;
		clk_en && time_up && !key_mode |=> mode_r == M_POS;
	endproperty
	a_timeout: assert property (p_timeout) else $error("idle timeout ignored"); // RULE_20

	property p_mode_cycle;
		clk_en && key_mode |=> mode_r == (($past(mode_r) == M_POS) ? M_TACH : ($past(mode_r) == M_TACH) ? M_OFFS :
			($past(mode_r) == M_OFFS) ? M_CHAN : M_POS);
	endproperty
	a_mode_cycle: assert property (p_mode_cycle) else $error("mode key sequence wrong"); // RULE_21

	property p_reset_chan;
		$rose(rst_n) |-> sel_chan_r == CHAN_MIN;
	endproperty
	a_reset_chan: assert property (p_reset_chan) else $error("channel not one after reset"); // RULE_22

endmodule

// File: verilog/pls_pkg.sv
// Shared constants and types of the limit switch programming logic.
// Assumes a single 40 MHz system clock; all angles are whole degrees.
package pls_pkg;

	// Clock and timing
	localparam longint unsigned CLK_HZ          = 64'd40_000_000;
	localparam real             OFFSET_SHOW_S   = 2.5;
	localparam longint unsigned OFFSET_SHOW_CYC = longint'(OFFSET_SHOW_S * 40_000_000.0);
	localparam longint unsigned IDLE_TIMEOUT_MIN = 64'd1;
	localparam longint unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_MIN * 64'd60 * CLK_HZ;
	localparam int              CNT_W           = 32;

	// Angles
	localparam int              ANGLE_W    = 9;
	localparam logic [8:0]      ANGLE_ZERO = 9'h000;
	localparam logic [8:0]      ANGLE_MAX  = 9'h167;
	localparam logic [9:0]      ANGLE_SPAN = 10'h168;

	// Channels
	localparam int              NUM_CHAN = 8;
	localparam int              IDX_W    = 3;
	localparam logic [3:0]      CHAN_MIN = 4'h1;
	localparam logic [3:0]      CHAN_MAX = 4'h8;

	// Operating modes
	typedef enum logic [2:0] {
		M_POS   = 3'b000,
		M_TACH  = 3'b001,
		M_OFFS  = 3'b010,
		M_CHAN  = 3'b011,
		M_ONSP  = 3'b100,
		M_OFFSP = 3'b101
	} mode_e;

	// Contents state of one channel
	typedef enum logic [1:0] {
		SP_NULL = 2'b00,
		SP_PAIR = 2'b01,
		SP_ALL  = 2'b10
	} sp_state_e;

	// Symbol shown in the right window
	typedef enum logic [1:0] {
		SYM_VALUE = 2'b00,
		SYM_NULL  = 2'b01,
		SYM_ALL   = 2'b10,
		SYM_BLANK = 2'b11
	} sym_e;

	typedef struct packed {
		sp_state_e  st;
		logic [8:0] on_ang;
		logic [8:0] off_ang;
	} sp_entry_s;

	localparam sp_entry_s ENTRY_EMPTY = '{st: SP_NULL, on_ang: 9'h000, off_ang: 9'h000};

endpackage

// File: verilog/setpoint_mem.sv
// Eight-entry setpoint store with an edit port and a scan port.
// Assumes one clock; contents are not touched by reset, only by factory_clear.
`timescale 1ns/1ps
module setpoint_mem
	import pls_pkg::*;
(
	// Clock and control
	input  wire logic clk_sys,
	input  wire logic clk_en,
	input  wire logic factory_clear,
	// Controller side
	sp_mem_if.mem     port
);

	sp_entry_s mem [NUM_CHAN];

	////////////////////////////////////////////////////////////////////////
	// Storage; models nonvolatile memory so reset leaves it alone
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			if (factory_clear) begin
				for (int i = 0; i < NUM_CHAN; i++) begin
					mem[i] <= ENTRY_EMPTY;
				end
			end else if (port.we) begin
				mem[port.waddr] <= port.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered reads; edit port bypasses a same-address write
	always_ff @(posedge clk_sys) begin
		if (clk_en) begin
			if (factory_clear) begin
				port.rdata <= ENTRY_EMPTY;
			end else if (port.we && port.waddr == port.raddr) begin
				port.rdata <= port.wdata;
			end else begin
				port.rdata <= mem[port.raddr];
			end
			port.scan_data <= factory_clear ? ENTRY_EMPTY : mem[port.scan_addr];
		end
	end

endmodule

// File: verilog/sp_mem_if.sv
// Carrier between the programming controller and the setpoint store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sp_mem_if;
	import pls_pkg::*;

	logic      we;
	logic [2:0] waddr;
	sp_entry_s wdata;
	logic [2:0] raddr;
	sp_entry_s rdata;
	logic [2:0] scan_addr;
	sp_entry_s scan_data;

	modport ctrl (output we, waddr, wdata, raddr, scan_addr, input rdata, scan_data);
	modport mem  (input we, waddr, wdata, raddr, scan_addr, output rdata, scan_data);
endinterface
